// File: ppcp_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef PPCP_REGS_SVH
`define PPCP_REGS_SVH
// register indices; byte address is four times the index
`define PPCP_IDX_PORT_CONFIG 6'h20
`define PPCP_IDX_POWER_STATUS 6'h21
`define PPCP_IDX_INT_STATUS 6'h22
`define PPCP_IDX_INT_CLEAR 6'h23
`define PPCP_IDX_INT_ENABLE 6'h24
// port configuration fields
`define PPCP_CFG_ENABLE 0
`define PPCP_CFG_ADDR_LO 1
`define PPCP_CFG_ADDR_HI 2
`define PPCP_CFG_IRQ_SEL 3
// power management and status fields
`define PPCP_PS_DIRECT_PD 0
`define PPCP_PS_IDLE 1
`define PPCP_PS_SOFT_RESET 2
`define PPCP_PS_AUTO_PD_EN 3
`define PPCP_PS_FIFO_ERR 5
// interrupt status, clear and enable layout
`define PPCP_INT_FIFO_ERR 0
`define PPCP_INT_IDLE 1
`define PPCP_INT_SHORT_RST 2
`define PPCP_INT_BITS 3
// address select codes and decoded ranges
`define PPCP_ADDR_DEFAULT 2'h0
`define PPCP_ADDR_ALT 2'h1
`define PPCP_ADDR_MONO 2'h2
`define PPCP_ADDR_RSVD 2'h3
`define PPCP_BASE_378 10'h378
`define PPCP_BASE_278 10'h278
`define PPCP_BASE_3BC 10'h3bc
`define PPCP_SPAN_WIDE 10'h007
`define PPCP_SPAN_MONO 10'h002
// reset values and strap settle count
`define PPCP_ENABLE_RESET 1'b0
`define PPCP_IRQ_SEL_RESET 1'b0
`define PPCP_SETTLE_CYC 2'h2
// timing
`define PPCP_CLK_NS 20
`define PPCP_SRST_MIN_NS 1130
`define PPCP_SRST_MIN_CYC ((`PPCP_SRST_MIN_NS + `PPCP_CLK_NS - 1) / `PPCP_CLK_NS)
`endif

// File: ppcp_pkg.sv
// types shared by the port configuration and power block
package ppcp_pkg;
   typedef enum logic [1:0] {
      strap_basic_mode,
      strap_extended_mode,
      software_motherboard_mode,
      software_addin_mode
   } ppcp_cfg_mode_e;
   typedef struct packed {
      ppcp_cfg_mode_e mode;
      logic [1:0] port_address_select;
      logic port_irq_select;
      logic port_enable_bit;
   } ppcp_strap_s;
   typedef struct packed {
      logic [9:0] base;
      logic [9:0] last;
      logic valid;
   } ppcp_decode_s;
   typedef enum logic [1:0] {st_settle, st_load, st_run} ppcp_boot_e;
endpackage

// File: ppcp_sync_bank.sv
// two-flop synchronisers, one per bit
`timescale 1ns/10ps
module ppcp_sync_bank #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;
   genvar i;
   // first stage is read only by the second stage
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               meta_reg[i] <= 1'b0;
               dout[i] <= 1'b0;
            end
            else
            begin
               meta_reg[i] <= din[i];
               dout[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
endmodule // ppcp_sync_bank

// File: ppcp_srst_width.sv
// soft reset pulse width monitor, flags pulses shorter than the minimum
`timescale 1ns/10ps
`include "ppcp_regs.svh"
module ppcp_srst_width (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic soft_reset,
   output logic short_pulse
);
   localparam logic [5:0] MIN_CYC = 6'(`PPCP_SRST_MIN_CYC);
   logic [5:0] count_reg;
   logic prev_reg;
   // count high cycles, saturating so a long hold cannot wrap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_reg <= 6'h00;
         prev_reg <= 1'b0;
      end
      else
      begin
         prev_reg <= soft_reset;
         if (!soft_reset)
            count_reg <= 6'h00;
         else if (count_reg != MIN_CYC)
            count_reg <= count_reg + 6'h01;
      end
   end
   // falling edge with too few cycles: the host broke its timing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         short_pulse <= 1'b0;
      else
         short_pulse <= prev_reg & ~soft_reset & (count_reg < MIN_CYC); // [RULE9]
   end
   short_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
      (prev_reg && !soft_reset && count_reg == MIN_CYC) |=> !short_pulse)
      else $error("full-width soft reset flagged as short");
endmodule // ppcp_srst_width

// File: ppcp_top.sv
// parallel port configuration and power management register block on apb
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "ppcp_regs.svh"
//
// Contract
// [RULE1] address select loads straps only in strap modes, else code 00 (378-37F)
// [RULE2] software enables the port and picks irq and address in one step
// [RULE3] enable bit 0 off, 1 on; defaults 0 in software modes, strap otherwise
// [RULE4] while disabled, irq and dma request outputs are tristated
// [RULE5] fifo error flag bit 5 sets on fifo underrun or overrun; the code ignores both while soft reset bit 2 is set
// [RULE6] writing 1 to soft reset bit clears the fifo error flag
// [RULE7] auto powerdown bit 3 allows powerdown when idle; 0 never powers down
// [RULE8] soft reset bit 2 holds the port as after a hard reset
// [RULE9] host pulses soft reset high for at least 1.13 us
// [RULE10] idle flag bit 1 is fifo empty and no interface activity
// [RULE11] direct powerdown bit 0: 1 enters powerdown, 0 leaves it
// [RULE12] soft reset also takes the port out of direct powerdown
// [RULE13] code 01 decodes 278-27F, 10 decodes 3BC-3BE except epp, 11 reserved
module ppcp_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ppcp_pkg::ppcp_strap_s strap_pins,
   input wire logic port_pin_activity,
   input wire logic fifo_empty,
   input wire logic fifo_underrun,
   input wire logic fifo_overrun,
   input wire logic port_epp_mode,
   input wire logic core_irq,
   input wire logic core_dma_request,
   output logic irq5_out,
   output logic irq5_oe,
   output logic irq7_out,
   output logic irq7_oe,
   output logic port_dma_request,
   output logic port_dma_oe,
   output logic port_core_reset_n,
   output logic auto_powerdown,
   output logic direct_powerdown,
   output ppcp_pkg::ppcp_decode_s decode_out,
   output logic irq
);
   import ppcp_pkg::*;

   ppcp_boot_e boot_reg;
   logic [1:0] settle_reg;
   ppcp_strap_s strap_sync;
   logic activity_sync;
   logic hw_mode;
   logic access;
   logic hit;
   logic wr_fire;
   logic [5:0] idx;
   logic [7:0] wbyte;
   logic wr_cfg;
   logic wr_ps;
   logic wr_clr;
   logic wr_ien;
   logic [31:0] rd_mux;
   logic port_enable_bit_reg;
   logic [1:0] port_address_select_reg;
   logic port_irq_select_reg;
   logic auto_powerdown_enable_reg;
   logic soft_reset_reg;
   logic direct_powerdown_reg;
   logic fifo_error_flag_reg;
   logic port_idle_flag_reg;
   logic idle_next;
   logic fifo_event;
   logic short_pulse;
   logic [`PPCP_INT_BITS-1:0] events;
   logic [`PPCP_INT_BITS-1:0] int_status_reg;
   logic [`PPCP_INT_BITS-1:0] int_status_next;
   logic [`PPCP_INT_BITS-1:0] int_enable_reg;
   logic [`PPCP_INT_BITS-1:0] int_clear;
   logic port_live;

   // straps and the interface activity pin come from outside the clock domain
   ppcp_sync_bank #(
      .WIDTH(7)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({strap_pins, port_pin_activity}),
      .dout({strap_sync, activity_sync})
   );

   ppcp_srst_width u_srst (
      .pclk(pclk),
      .presetn(presetn),
      .soft_reset(soft_reset_reg),
      .short_pulse(short_pulse)
   );

   assign hw_mode = (strap_sync.mode == strap_basic_mode) ||
                    (strap_sync.mode == strap_extended_mode);

   // straps are caught after release, once the synchroniser has settled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot_reg <= st_settle;
         settle_reg <= 2'h0;
      end
      else
      begin
         unique case (boot_reg)
            st_settle:
            begin
               settle_reg <= settle_reg + 2'h1;
               if (settle_reg == `PPCP_SETTLE_CYC)
                  boot_reg <= st_load;
            end
            st_load: boot_reg <= st_run;
            st_run: boot_reg <= st_run;
         endcase
      end
   end

   // bus decode; one wait state so read data leaves a flop
   assign access = psel & penable;
   assign idx = paddr[7:2];
   assign hit = (idx >= `PPCP_IDX_PORT_CONFIG) && (idx <= `PPCP_IDX_INT_ENABLE);
   assign wr_fire = access & pready & pwrite & hit;
   assign wbyte = pwdata[7:0];
   assign wr_cfg = wr_fire && (idx == `PPCP_IDX_PORT_CONFIG);
   assign wr_ps = wr_fire && (idx == `PPCP_IDX_POWER_STATUS);
   assign wr_clr = wr_fire && (idx == `PPCP_IDX_INT_CLEAR);
   assign wr_ien = wr_fire && (idx == `PPCP_IDX_INT_ENABLE);

   // read mux; reserved bits and the clear register read as zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (idx)
         `PPCP_IDX_PORT_CONFIG:
         begin
            rd_mux[`PPCP_CFG_ENABLE] = port_enable_bit_reg;
            rd_mux[`PPCP_CFG_ADDR_HI:`PPCP_CFG_ADDR_LO] = port_address_select_reg;
            rd_mux[`PPCP_CFG_IRQ_SEL] = port_irq_select_reg;
         end
         `PPCP_IDX_POWER_STATUS:
         begin
            rd_mux[`PPCP_PS_DIRECT_PD] = direct_powerdown_reg;
            rd_mux[`PPCP_PS_IDLE] = port_idle_flag_reg;
            rd_mux[`PPCP_PS_SOFT_RESET] = soft_reset_reg;
            rd_mux[`PPCP_PS_AUTO_PD_EN] = auto_powerdown_enable_reg;
            rd_mux[`PPCP_PS_FIFO_ERR] = fifo_error_flag_reg;
         end
         `PPCP_IDX_INT_STATUS: rd_mux[`PPCP_INT_BITS-1:0] = int_status_reg;
         `PPCP_IDX_INT_ENABLE: rd_mux[`PPCP_INT_BITS-1:0] = int_enable_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // apb answer: pready one cycle after the access phase starts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= access & ~pready;
         if (access && !pready)
         begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~hit;
         end
         else
         begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end

   // port configuration; strap modes load straps, software modes keep defaults
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_enable_bit_reg <= `PPCP_ENABLE_RESET;
         port_address_select_reg <= `PPCP_ADDR_DEFAULT;
         port_irq_select_reg <= `PPCP_IRQ_SEL_RESET;
      end
      else if (boot_reg == st_load)
      begin
         if (hw_mode)
         begin
            port_enable_bit_reg <= strap_sync.port_enable_bit; // [RULE3]
            port_address_select_reg <= strap_sync.port_address_select; // [RULE1]
            port_irq_select_reg <= strap_sync.port_irq_select;
         end
         else
         begin
            port_enable_bit_reg <= `PPCP_ENABLE_RESET; // [RULE3] [RULE2]
            port_address_select_reg <= `PPCP_ADDR_DEFAULT; // [RULE1]
            port_irq_select_reg <= `PPCP_IRQ_SEL_RESET;
         end
      end
      else if (wr_cfg)
      begin
         port_enable_bit_reg <= wbyte[`PPCP_CFG_ENABLE];
         port_irq_select_reg <= wbyte[`PPCP_CFG_IRQ_SEL];
         // reserved code is refused on a write; only a strap load can hand it to the decoder
         if (wbyte[`PPCP_CFG_ADDR_HI:`PPCP_CFG_ADDR_LO] != `PPCP_ADDR_RSVD) // [RULE13]
            port_address_select_reg <= wbyte[`PPCP_CFG_ADDR_HI:`PPCP_CFG_ADDR_LO];
      end
   end

   // power control bits written by software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         auto_powerdown_enable_reg <= 1'b0;
         soft_reset_reg <= 1'b0;
         direct_powerdown_reg <= 1'b0;
      end
      else
      begin
         if (wr_ps)
         begin
            auto_powerdown_enable_reg <= wbyte[`PPCP_PS_AUTO_PD_EN];
            soft_reset_reg <= wbyte[`PPCP_PS_SOFT_RESET];
         end
         // soft reset overrides any direct powerdown request
         if (soft_reset_reg || (wr_ps && wbyte[`PPCP_PS_SOFT_RESET])) // [RULE12]
            direct_powerdown_reg <= 1'b0;
         else if (wr_ps)
            direct_powerdown_reg <= wbyte[`PPCP_PS_DIRECT_PD]; // [RULE11]
      end
   end

   // fifo error is sticky; a new error in the clearing cycle still lands unless soft reset bit 2 is already set
   assign fifo_event = (fifo_underrun | fifo_overrun) & ~soft_reset_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fifo_error_flag_reg <= 1'b0;
      else if (fifo_event)
         fifo_error_flag_reg <= 1'b1; // [RULE5]
      else if (wr_ps && wbyte[`PPCP_PS_SOFT_RESET])
         fifo_error_flag_reg <= 1'b0; // [RULE6]
   end

   // idle is the same condition that allows auto powerdown
   assign idle_next = fifo_empty & ~activity_sync; // [RULE10]
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_idle_flag_reg <= 1'b0;
         auto_powerdown <= 1'b0;
      end
      else
      begin
         port_idle_flag_reg <= idle_next; // [RULE10]
         auto_powerdown <= auto_powerdown_enable_reg & port_idle_flag_reg; // [RULE7]
      end
   end

   // interrupt status: set beats clear for the same bit
   assign events[`PPCP_INT_FIFO_ERR] = fifo_event;
   assign events[`PPCP_INT_IDLE] = idle_next & ~port_idle_flag_reg;
   assign events[`PPCP_INT_SHORT_RST] = short_pulse;
   assign int_clear = wr_clr ? wbyte[`PPCP_INT_BITS-1:0] : '0;
   assign int_status_next = (int_status_reg & ~int_clear) | events;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_status_reg <= '0;
         int_enable_reg <= '0;
         irq <= 1'b0;
      end
      else
      begin
         int_status_reg <= int_status_next;
         if (wr_ien)
            int_enable_reg <= wbyte[`PPCP_INT_BITS-1:0];
         irq <= |(int_status_reg & int_enable_reg);
      end
   end

   // port-facing lines; a disabled or resetting port floats irq and dma
   assign port_live = port_enable_bit_reg & ~soft_reset_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq5_out <= 1'b0;
         irq5_oe <= 1'b0;
         irq7_out <= 1'b0;
         irq7_oe <= 1'b0;
         port_dma_request <= 1'b0;
         port_dma_oe <= 1'b0;
         port_core_reset_n <= 1'b0;
         direct_powerdown <= 1'b0;
      end
      else
      begin
         irq5_out <= core_irq & port_live & ~port_irq_select_reg;
         irq5_oe <= port_live & ~port_irq_select_reg; // [RULE4]
         irq7_out <= core_irq & port_live & port_irq_select_reg;
         irq7_oe <= port_live & port_irq_select_reg; // [RULE4]
         port_dma_request <= core_dma_request & port_live;
         port_dma_oe <= port_live; // [RULE4]
         // core stays in reset until the straps are in and soft reset drops
         port_core_reset_n <= ~soft_reset_reg & (boot_reg == st_run); // [RULE8]
         direct_powerdown <= direct_powerdown_reg; // [RULE11]
      end
   end

   // io address decode from the selected range
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         decode_out <= '0;
      else
      begin
         unique case (port_address_select_reg)
            `PPCP_ADDR_DEFAULT:
            begin
               decode_out.base <= `PPCP_BASE_378;
               decode_out.last <= `PPCP_BASE_378 + `PPCP_SPAN_WIDE;
               decode_out.valid <= port_live;
            end
            `PPCP_ADDR_ALT:
            begin
               decode_out.base <= `PPCP_BASE_278; // [RULE13]
               decode_out.last <= `PPCP_BASE_278 + `PPCP_SPAN_WIDE;
               decode_out.valid <= port_live;
            end
            `PPCP_ADDR_MONO:
            begin
               decode_out.base <= `PPCP_BASE_3BC;
               decode_out.last <= `PPCP_BASE_3BC + `PPCP_SPAN_MONO;
               decode_out.valid <= port_live & ~port_epp_mode; // [RULE13]
            end
            `PPCP_ADDR_RSVD:
            begin
               decode_out.base <= `PPCP_BASE_378;
               decode_out.last <= `PPCP_BASE_378;
               decode_out.valid <= 1'b0;
            end
         endcase
      end
   end

   sw_default_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      (boot_reg == st_load && !hw_mode) |=>
      (port_address_select_reg == 2'h0 && !port_enable_bit_reg))
      else $error("software mode defaults not applied");
   strap_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      (boot_reg == st_load && hw_mode) |=>
      (port_enable_bit_reg == $past(strap_sync.port_enable_bit)))
      else $error("strap enable not loaded");
   tristate_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      !port_enable_bit_reg |=> (!irq5_oe && !irq7_oe && !port_dma_oe))
      else $error("irq or dma driven while port disabled");
   ferr_set_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      fifo_event |=> fifo_error_flag_reg ##1 (fifo_error_flag_reg || $past(wr_ps && wbyte[2])))
      else $error("fifo error flag missed an event");
   ferr_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      (wr_ps && wbyte[2] && !fifo_event) |=> !fifo_error_flag_reg)
      else $error("fifo error flag not cleared");
   auto_pd_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
      (auto_powerdown_enable_reg && idle_next) |=>
      ##1 (auto_powerdown == $past(auto_powerdown_enable_reg)))
      else $error("auto powerdown mismatch");
   soft_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
      $rose(soft_reset_reg) |=> (!port_core_reset_n && !port_dma_oe)
      until !soft_reset_reg)
      else $error("port not held during soft reset");
   idle_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
      (fifo_empty && !activity_sync) |=> port_idle_flag_reg)
      else $error("idle flag not set");
   dpd_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
      (wr_ps && wbyte[0] && !wbyte[2] && !soft_reset_reg) |=> ##1 direct_powerdown)
      else $error("direct powerdown not entered");
   srst_dpd_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
      soft_reset_reg |=> !direct_powerdown_reg)
      else $error("soft reset left direct powerdown set");
   rsvd_code_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
      (wr_cfg && wbyte[2:1] == 2'h3 && boot_reg == st_run) |=>
      $stable(port_address_select_reg))
      else $error("reserved address code accepted");
endmodule // ppcp_top

// File: ppcp_port_model.sv
// port core stand-in: fifo events, pin activity and request lines
`timescale 1ns/10ps
module ppcp_port_model (
   input wire logic pclk,
   input wire logic busy,
   input wire logic kick_under,
   input wire logic kick_over,
   output logic fifo_empty,
   output logic fifo_underrun,
   output logic fifo_overrun,
   output logic port_pin_activity,
   output logic core_irq,
   output logic core_dma_request
);
   // known levels before the first edge
   initial
   begin
      fifo_empty = 1'b1;
      fifo_underrun = 1'b0;
      fifo_overrun = 1'b0;
      port_pin_activity = 1'b0;
      core_irq = 1'b0;
      core_dma_request = 1'b0;
   end
   // requests keep moving so a frozen level cannot pass for a driven one
   always @(posedge pclk)
   begin
      fifo_empty <= !busy;
      port_pin_activity <= busy;
      fifo_underrun <= kick_under;
      fifo_overrun <= kick_over;
      core_irq <= !core_irq;
      core_dma_request <= 1'($urandom);
   end
endmodule // ppcp_port_model

// File: testbench.sv
// self-checking bench for the port configuration and power block
`timescale 1ns/10ps
`include "ppcp_regs.svh"
module testbench;
   import ppcp_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, epp, busy, k_un, k_ov;
   logic f_em, f_un, f_ov, act, c_irq, c_dma, i5, i5oe, i7, i7oe, dreq, doe, crst_n, apd, dpd;
   logic irq;
   logic [1:0] pick;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   ppcp_strap_s straps;
   ppcp_decode_s dec;
   logic [32:0] expq[$];
   logic [20:0] dtab[3];
   int n_fail, n_checks;
   ppcp_top u_ppcp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .strap_pins(straps), .port_pin_activity(act), .fifo_empty(f_em),
      .fifo_underrun(f_un), .fifo_overrun(f_ov), .port_epp_mode(epp), .core_irq(c_irq),
      .core_dma_request(c_dma), .irq5_out(i5), .irq5_oe(i5oe), .irq7_out(i7),
      .irq7_oe(i7oe), .port_dma_request(dreq), .port_dma_oe(doe),
      .port_core_reset_n(crst_n), .auto_powerdown(apd), .direct_powerdown(dpd),
      .decode_out(dec), .irq(irq));
   ppcp_port_model u_ppcp_port_model (.pclk(pclk), .busy(busy), .kick_under(k_un),
      .kick_over(k_ov), .fifo_empty(f_em), .fifo_underrun(f_un), .fifo_overrun(f_ov),
      .port_pin_activity(act), .core_irq(c_irq), .core_dma_request(c_dma));
   // 50 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'($urandom), d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (i == 20)
      begin
         n_fail++;
         print_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic err = 1'b0);
      expq.push_back({err, 24'h0, e});
      apb(1'b0, idx, 8'h00);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic kick(input logic over);
      @(posedge pclk);
      k_ov <= over;
      k_un <= !over;
      @(posedge pclk);
      k_ov <= 1'b0;
      k_un <= 1'b0;
   endtask
   // reserved address code never strapped, it has no decode
   task automatic do_reset(input int m);
      @(posedge pclk);
      presetn <= 1'b0;
      straps <= {2'(m), 2'($urandom_range(2)), 2'($urandom)};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
   endtask
   // read completions pop the oldest expectation
   always @(posedge pclk)
   begin
      if (psel && penable && pready && !pwrite)
      begin
         check({31'h0, pslverr}, {31'h0, expq[0][32]});
         check(prdata, expq[0][31:0]);
         void'(expq.pop_front());
      end
   end
   initial
   begin
      {presetn, psel, penable, pwrite, epp, busy, k_un, k_ov} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      straps = 6'h00;
      dtab = '{{10'h378, 10'h37f, 1'b1}, {10'h278, 10'h27f, 1'b1}, {10'h3bc, 10'h3be, 1'b1}};
      void'($urandom(32'h0924_dd43));
      for (int m = 0; m < 4; m++)
      begin
         do_reset(m);
         // register layout is irq select, address select, enable
         rd(`PPCP_IDX_PORT_CONFIG,
            m < 2 ? {4'h0, straps[1], straps[3:2], straps[0]} : 8'h00);
      end
      settle(2);
      check(32'({i5oe, i7oe, doe}), 32'h0);
      rd(6'h10, 8'h00, 1'b1);
      $display("reset defaults done");
      for (int c = 0; c < 3; c++)
      begin
         wr(`PPCP_IDX_PORT_CONFIG, 8'(9 + 2 * c));
         settle(3);
         check(32'(dec), 32'(dtab[c]));
         check(32'({i5oe, i7oe, doe}), 32'h3);
      end
      // enabled port on the second line passes core requests one edge later
      pick = {c_irq, c_dma};
      settle(1);
      check(32'({i5, i7, dreq}), 32'({1'b0, pick}));
      wr(`PPCP_IDX_PORT_CONFIG, 8'h0f);
      rd(`PPCP_IDX_PORT_CONFIG, 8'h0d);
      @(posedge pclk) epp <= 1'b1;
      settle(3);
      check(32'(dec.valid), 32'h0);
      @(posedge pclk) epp <= 1'b0;
      $display("decode done");
      wr(`PPCP_IDX_POWER_STATUS, 8'h01);
      settle(3);
      check(32'(dpd), 32'h1);
      wr(`PPCP_IDX_POWER_STATUS, 8'h00);
      settle(3);
      check(32'(dpd), 32'h0);
      wr(`PPCP_IDX_INT_CLEAR, 8'h07);
      for (int k = 0; k < 2; k++)
      begin
         wr(`PPCP_IDX_INT_ENABLE, 8'h01);
         kick(k[0]);
         settle(3);
         check(32'(irq), 32'h1);
         rd(`PPCP_IDX_POWER_STATUS, 8'h22);
         rd(`PPCP_IDX_INT_STATUS, 8'h01);
         wr(`PPCP_IDX_INT_ENABLE, 8'h00);
         settle(2);
         check(32'(irq), 32'h0);
         wr(`PPCP_IDX_INT_CLEAR, 8'h01);
         rd(`PPCP_IDX_INT_STATUS, 8'h00);
         wr(`PPCP_IDX_POWER_STATUS, 8'h01);
         wr(`PPCP_IDX_POWER_STATUS, 8'h05);
         rd(`PPCP_IDX_POWER_STATUS, 8'h06);
         settle(2);
         check(32'({crst_n, dpd, i5oe, i7oe, doe}), 32'h0);
         repeat (60) @(posedge pclk);
         wr(`PPCP_IDX_POWER_STATUS, 8'h00);
         settle(8);
         check(32'({crst_n, i5oe, i7oe, doe}), 32'hb);
      end
      $display("fifo error and soft reset done");
      wr(`PPCP_IDX_POWER_STATUS, 8'h08);
      settle(4);
      check(32'(apd), 32'h1);
      rd(`PPCP_IDX_POWER_STATUS, 8'h0a);
      @(posedge pclk) busy <= 1'b1;
      settle(5);
      check(32'(apd), 32'h0);
      rd(`PPCP_IDX_POWER_STATUS, 8'h08);
      @(posedge pclk) busy <= 1'b0;
      wr(`PPCP_IDX_POWER_STATUS, 8'h00);
      settle(5);
      check(32'(apd), 32'h0);
      rd(`PPCP_IDX_POWER_STATUS, 8'h02);
      $display("powerdown done");
      // a pulse far below the minimum width must raise the short-pulse event
      wr(`PPCP_IDX_POWER_STATUS, 8'h04);
      wr(`PPCP_IDX_POWER_STATUS, 8'h00);
      settle(4);
      rd(`PPCP_IDX_INT_STATUS, 8'h06);
      $display("short soft reset done");
      settle(2);
      print_verdict();
   end
endmodule // testbench
